// ==== include/dfd_defines.svh ====
// constants for the drive input function decoder
`ifndef DFD_DEFINES_SVH
`define DFD_DEFINES_SVH

`define DFD_CLK_KHZ        125000
`define DFD_STEP_MIN_MS    14
`define DFD_GATE_MS        1000
`define DFD_PCT_FULL       100
`define DFD_REF_STEP       16'h0001
`define DFD_FREQ_STEP      16'h0001
`define DFD_VMIN_DEF_MV    16'h0000
`define DFD_VMAX_DEF_MV    16'h2710
`define DFD_IMIN_DEF_UA    16'h0fa0
`define DFD_IMAX_DEF_UA    16'h4e20
`define DFD_TIMEOUT_MV     16'h03e8

`define DFD_NPIN           18
`define DFD_PIN_IDLE       18'h3c100
`define DFD_P_UP           0
`define DFD_P_DOWN         1
`define DFD_P_CATCH        2
`define DFD_P_SLOW         3
`define DFD_P_RAMP         4
`define DFD_P_PLSB         5
`define DFD_P_PMSB         6
`define DFD_P_PON          7
`define DFD_P_HALT_N       8
`define DFD_P_SLSB         9
`define DFD_P_SMSB         10
`define DFD_P_RSTART       11
`define DFD_P_TRKA         12
`define DFD_P_TRKB         13
`define DFD_P_COAST_N      14
`define DFD_P_QSTOP_N      15
`define DFD_P_DCBRK_N      16
`define DFD_P_STOP_N       17

`endif

// ==== include/dfd_pkg.sv ====
// types for the drive input function decoder
package dfd_pkg;
    typedef enum logic [1:0] {
        DFD_HOLD_NONE = 2'b00,
        DFD_HOLD_REF  = 2'b01,
        DFD_HOLD_OUT  = 2'b10
    } dfd_hold_t;

    typedef enum logic [2:0] {
        DFD_PM_NONE      = 3'b000,
        DFD_PM_PULSE_REF = 3'b001,
        DFD_PM_PULSE_FB  = 3'b010,
        DFD_PM_PULSE_CNT = 3'b011,
        DFD_PM_ENC_REF   = 3'b100,
        DFD_PM_ENC_FB    = 3'b101,
        DFD_PM_ENC_CNT   = 3'b110
    } dfd_pulse_t;

    typedef enum logic [1:0] {
        DFD_AIN_NONE  = 2'b00,
        DFD_AIN_REF   = 2'b01,
        DFD_AIN_FB    = 2'b10,
        DFD_AIN_SWEEP = 2'b11
    } dfd_ain_t;

    typedef enum logic [1:0] {
        DFD_STEP_IDLE = 2'b00,
        DFD_STEP_HIGH = 2'b01,
        DFD_STEP_LOW  = 2'b10
    } dfd_step_t;
endpackage

// ==== hw/dfd_decoder.sv ====
// drive input function decoder: digital and analogue input functions to drive commands
// Contract
// RULE1 - in output hold only coast, quick stop or dc brake inputs stop the drive
// RULE2 - increase and decrease inputs act only while a hold mode is selected
// RULE3 - increase raises, decrease lowers held value; held frequency uses second ramp
// RULE4 - a step needs 14 ms high then 14 ms low; one lsb per step
// RULE5 - decrease beats increase, slow-down beats catch-up when both are asserted
// RULE6 - held reference adjustable while stopped and reloaded from backup after power loss; code: reference hold after reset takes base_ref, not the backup
// RULE7 - catch-up raises, slow-down lowers reference by programmed percent, else unchanged
// RULE8 - ramp select low picks first ramp set, high picks second
// RULE9 - two preset select bits pick one of four preset references
// RULE10 - in preset reference function, preset enable picks preset over remote reference
// RULE11 - low accurate halt inverse input ramps motor to standstill on selected ramp
// RULE12 - pulse reference maps 0 Hz to minimum and pulse maximum to maximum
// RULE13 - pulse or encoder feedback is pulse frequency scaled to maximum pulse frequency
// RULE14 - pulse counting mode triggers accurate halt when counter value is reached
// RULE15 - setup select bits pick one of four sets only when switching enabled
// RULE16 - reset-and-start input resets the drive, then ramps to preset reference
// RULE17 - encoder modes decode quadrature tracks a and b with direction
// RULE18 - encoder reference maps 0 Hz to minimum and pulse maximum to maximum
// RULE19 - unused analogue inputs ignored; reference inputs summed into the reference
// RULE20 - sweep input scales linearly from zero at minimum to programmed delta frequency
// RULE21 - programmed input min and max map to reference or feedback min and max
// RULE22 - signal time-out on voltage input needs minimum scaling above 1 volt
`timescale 1ns/1ps
`include "dfd_defines.svh"

module dfd_decoder #(
    parameter int STEP_CYCLES = `DFD_STEP_MIN_MS * `DFD_CLK_KHZ,
    parameter int GATE_CYCLES = `DFD_GATE_MS * `DFD_CLK_KHZ
) (
    input  wire logic                CLOCK,
    input  wire logic                RST,
    input  wire logic                SPEED_UP,
    input  wire logic                SPEED_DOWN,
    input  wire logic                CATCH_UP,
    input  wire logic                SLOW_DOWN,
    input  wire logic                RAMP_SELECT,
    input  wire logic                PRESET_LSB,
    input  wire logic                PRESET_MSB,
    input  wire logic                PRESET_ENABLE,
    input  wire logic                ACCURATE_HALT_INVERSE,
    input  wire logic                SETUP_LSB,
    input  wire logic                SETUP_MSB,
    input  wire logic                RESET_AND_START,
    input  wire logic                TRACK_A,
    input  wire logic                TRACK_B,
    input  wire logic                COAST_N,
    input  wire logic                QUICK_STOP_N,
    input  wire logic                DC_BRAKE_N,
    input  wire logic                STOP_N,
    input  wire dfd_pkg::dfd_hold_t  HOLD_MODE,
    input  wire dfd_pkg::dfd_pulse_t PULSE_MODE,
    input  wire dfd_pkg::dfd_ain_t   VOLT_FUNC,
    input  wire dfd_pkg::dfd_ain_t   CURR_FUNC,
    input  wire logic                PRESET_FUNC,
    input  wire logic                MULTISETUP_EN,
    input  wire logic                SCALE_CUSTOM,
    input  wire logic [15:0]         RETAINED_REF,
    input  wire logic [15:0]         CURRENT_FREQ,
    input  wire logic [15:0]         REMOTE_REF,
    input  wire logic [15:0]         PRESET_REF_1,
    input  wire logic [15:0]         PRESET_REF_2,
    input  wire logic [15:0]         PRESET_REF_3,
    input  wire logic [15:0]         PRESET_REF_4,
    input  wire logic [7:0]          CATCH_PCT,
    input  wire logic [15:0]         REF_MIN,
    input  wire logic [15:0]         REF_MAX,
    input  wire logic [15:0]         FB_MIN,
    input  wire logic [15:0]         FB_MAX,
    input  wire logic [15:0]         PULSE_MAX_HZ,
    input  wire logic [15:0]         COUNT_TARGET,
    input  wire logic [15:0]         SWEEP_DELTA,
    input  wire logic [15:0]         VOLT_IN,
    input  wire logic [15:0]         VOLT_MIN,
    input  wire logic [15:0]         VOLT_MAX,
    input  wire logic [15:0]         CURR_IN,
    input  wire logic [15:0]         CURR_MIN,
    input  wire logic [15:0]         CURR_MAX,
    output logic [15:0]              REF_OUT,
    output logic [15:0]              HELD_REF,
    output logic [15:0]              HELD_FREQ,
    output logic [15:0]              FEEDBACK_OUT,
    output logic [15:0]              SWEEP_FREQ,
    output logic                     RAMP2_SEL,
    output logic [1:0]               SETUP_SEL,
    output logic                     STOP_REQ,
    output logic                     HALT_REQ,
    output logic                     RESET_PULSE,
    output logic                     START_REQ,
    output logic                     ENC_REVERSE,
    output logic [15:0]              PULSE_FREQ,
    output logic [15:0]              PULSE_COUNT,
    output logic                     TIMEOUT_ARMED
);
    localparam int NPIN = `DFD_NPIN;
    // active-low stop pins rest high, so the synchroniser starts there to avoid a false stop
    localparam logic [NPIN-1:0] PIN_IDLE = `DFD_PIN_IDLE;

    function automatic logic [15:0] dfd_scale(input logic [15:0] x, input logic [15:0] imin,
            input logic [15:0] imax, input logic [15:0] omin, input logic [15:0] omax);
        logic [31:0] num;
        logic [15:0] xc;
        num = 32'h0;
        xc  = (x < imin) ? imin : ((x > imax) ? imax : x);
        if (imax <= imin || omax < omin) begin
            return omin;
        end
        num = 32'(xc - imin) * 32'(omax - omin);
        return 16'(32'(omin) + num / 32'(imax - imin));
    endfunction

    // three-stage synchronisers; a level is accepted only when stages two and three agree
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] s1_reg, s2_reg, s3_reg, lvl_reg;
    assign pin_raw = {STOP_N, DC_BRAKE_N, QUICK_STOP_N, COAST_N, TRACK_B, TRACK_A,
                      RESET_AND_START, SETUP_MSB, SETUP_LSB, ACCURATE_HALT_INVERSE,
                      PRESET_ENABLE, PRESET_MSB, PRESET_LSB, RAMP_SELECT, SLOW_DOWN,
                      CATCH_UP, SPEED_DOWN, SPEED_UP};

    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++) begin : g_sync
            always_ff @(posedge CLOCK) begin
                if (RST) begin
                    s1_reg[gi]  <= PIN_IDLE[gi];
                    s2_reg[gi]  <= PIN_IDLE[gi];
                    s3_reg[gi]  <= PIN_IDLE[gi];
                    lvl_reg[gi] <= PIN_IDLE[gi];
                end else begin
                    s1_reg[gi] <= pin_raw[gi];
                    s2_reg[gi] <= s1_reg[gi];
                    s3_reg[gi] <= s2_reg[gi];
                    if (s2_reg[gi] == s3_reg[gi]) begin
                        lvl_reg[gi] <= s3_reg[gi];
                    end
                end
            end
        end
    endgenerate

    wire hold_ref = (HOLD_MODE == dfd_pkg::DFD_HOLD_REF);
    wire hold_out = (HOLD_MODE == dfd_pkg::DFD_HOLD_OUT);
    wire hold_any = hold_ref | hold_out;
    wire up_lvl   = lvl_reg[`DFD_P_UP] & ~lvl_reg[`DFD_P_DOWN]; // [RULE5]
    wire dn_lvl   = lvl_reg[`DFD_P_DOWN];

    // step qualifier per direction: high for STEP_CYCLES, then low for STEP_CYCLES
    dfd_pkg::dfd_step_t step_state_reg [2];
    logic [31:0]        step_cnt_reg   [2];
    logic [1:0]         step_hit;
    wire  [1:0]         step_in = {dn_lvl, up_lvl};
    generate
        for (gi = 0; gi < 2; gi++) begin : g_step
            wire cnt_done = (step_cnt_reg[gi] >= 32'(STEP_CYCLES - 1));
            assign step_hit[gi] = (step_state_reg[gi] == dfd_pkg::DFD_STEP_LOW) &
                                  cnt_done & ~step_in[gi]; // [RULE4]
            always_ff @(posedge CLOCK) begin
                if (RST || !hold_any) begin // [RULE2]
                    step_state_reg[gi] <= dfd_pkg::DFD_STEP_IDLE;
                    step_cnt_reg[gi]   <= 32'h0;
                end else begin
                    case (step_state_reg[gi])
                        dfd_pkg::DFD_STEP_IDLE: begin
                            step_cnt_reg[gi] <= 32'h0;
                            if (step_in[gi]) begin
                                step_state_reg[gi] <= dfd_pkg::DFD_STEP_HIGH;
                            end
                        end
                        dfd_pkg::DFD_STEP_HIGH: begin
                            if (!step_in[gi]) begin
                                step_state_reg[gi] <= dfd_pkg::DFD_STEP_IDLE; // too short
                            end else if (cnt_done) begin
                                step_state_reg[gi] <= dfd_pkg::DFD_STEP_LOW;
                                step_cnt_reg[gi]   <= 32'h0;
                            end else begin
                                step_cnt_reg[gi] <= step_cnt_reg[gi] + 32'h1;
                            end
                        end
                        dfd_pkg::DFD_STEP_LOW: begin
                            if (step_in[gi]) begin
                                step_cnt_reg[gi] <= 32'h0; // break not long enough yet
                            end else if (cnt_done) begin
                                step_state_reg[gi] <= dfd_pkg::DFD_STEP_IDLE;
                            end else begin
                                step_cnt_reg[gi] <= step_cnt_reg[gi] + 32'h1;
                            end
                        end
                        default: step_state_reg[gi] <= dfd_pkg::DFD_STEP_IDLE;
                    endcase
                end
            end
        end
    endgenerate

    wire step_dn = step_hit[1];
    wire step_up = step_hit[0] & ~step_hit[1]; // [RULE5]

    // pulse and quadrature tracks, taken from the agreed levels
    wire trk_a = lvl_reg[`DFD_P_TRKA];
    wire trk_b = lvl_reg[`DFD_P_TRKB];
    logic        trk_a_q_reg;
    logic [31:0] gate_cnt_reg;
    logic [15:0] edge_cnt_reg;
    logic        count_done_reg;
    wire a_rise   = trk_a & ~trk_a_q_reg;
    wire gate_end = (gate_cnt_reg >= 32'(GATE_CYCLES - 1));
    wire is_enc   = PULSE_MODE inside {dfd_pkg::DFD_PM_ENC_REF, dfd_pkg::DFD_PM_ENC_FB,
                                       dfd_pkg::DFD_PM_ENC_CNT};
    wire is_cnt   = PULSE_MODE inside {dfd_pkg::DFD_PM_PULSE_CNT, dfd_pkg::DFD_PM_ENC_CNT};
    wire is_pref  = PULSE_MODE inside {dfd_pkg::DFD_PM_PULSE_REF,
                                       dfd_pkg::DFD_PM_ENC_REF}; // [RULE18]
    wire is_pfb   = PULSE_MODE inside {dfd_pkg::DFD_PM_PULSE_FB, dfd_pkg::DFD_PM_ENC_FB};
    wire cnt_hit  = is_cnt & a_rise & (PULSE_COUNT + 16'h1 >= COUNT_TARGET); // [RULE14]

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            trk_a_q_reg  <= 1'b0;
            gate_cnt_reg <= 32'h0;
            edge_cnt_reg <= 16'h0;
            PULSE_FREQ   <= 16'h0;
            ENC_REVERSE  <= 1'b0;
        end else begin
            trk_a_q_reg  <= trk_a;
            gate_cnt_reg <= gate_end ? 32'h0 : gate_cnt_reg + 32'h1;
            if (gate_end) begin
                PULSE_FREQ   <= edge_cnt_reg;
                edge_cnt_reg <= {15'h0, a_rise};
            end else if (a_rise && edge_cnt_reg != 16'hffff) begin
                edge_cnt_reg <= edge_cnt_reg + 16'h1;
            end
            if (a_rise && is_enc) begin
                ENC_REVERSE <= trk_b; // b already high at a's rise: reverse rotation [RULE17]
            end
        end
    end

    // count is cleared by reset-and-start, so a new batch starts from zero
    always_ff @(posedge CLOCK) begin
        if (RST || !is_cnt || RESET_PULSE) begin
            PULSE_COUNT    <= 16'h0;
            count_done_reg <= 1'b0;
        end else if (cnt_hit) begin
            PULSE_COUNT    <= PULSE_COUNT + 16'h1;
            count_done_reg <= 1'b1; // [RULE14]
        end else if (a_rise && !count_done_reg) begin
            PULSE_COUNT <= PULSE_COUNT + 16'h1;
        end
    end

    // analogue scaling
    wire [15:0] v_min = SCALE_CUSTOM ? VOLT_MIN : `DFD_VMIN_DEF_MV; // [RULE21]
    wire [15:0] v_max = SCALE_CUSTOM ? VOLT_MAX : `DFD_VMAX_DEF_MV;
    wire [15:0] i_min = SCALE_CUSTOM ? CURR_MIN : `DFD_IMIN_DEF_UA;
    wire [15:0] i_max = SCALE_CUSTOM ? CURR_MAX : `DFD_IMAX_DEF_UA;
    wire [15:0] v_ref = dfd_scale(VOLT_IN, v_min, v_max, REF_MIN, REF_MAX); // [RULE21]
    wire [15:0] i_ref = dfd_scale(CURR_IN, i_min, i_max, REF_MIN, REF_MAX);
    wire [15:0] v_fb  = dfd_scale(VOLT_IN, v_min, v_max, FB_MIN, FB_MAX);
    wire [15:0] i_fb  = dfd_scale(CURR_IN, i_min, i_max, FB_MIN, FB_MAX);
    wire [15:0] v_sw  = dfd_scale(VOLT_IN, v_min, v_max, 16'h0, SWEEP_DELTA); // [RULE20]
    wire [15:0] i_sw  = dfd_scale(CURR_IN, i_min, i_max, 16'h0, SWEEP_DELTA);
    wire [15:0] p_ref = dfd_scale(PULSE_FREQ, 16'h0, PULSE_MAX_HZ, REF_MIN, REF_MAX);
    wire [15:0] p_fb  = dfd_scale(PULSE_FREQ, 16'h0, PULSE_MAX_HZ, FB_MIN, FB_MAX);

    // several reference sources add; the sum saturates rather than wraps
    wire [17:0] ain_sum = 18'((VOLT_FUNC == dfd_pkg::DFD_AIN_REF) ? v_ref : 16'h0) +
                          18'((CURR_FUNC == dfd_pkg::DFD_AIN_REF) ? i_ref : 16'h0) +
                          18'(is_pref ? p_ref : 16'h0) + 18'(REMOTE_REF); // [RULE19] [RULE12]
    wire [15:0] remote_sum = (ain_sum > 18'h0ffff) ? 16'hffff : ain_sum[15:0];

    wire [1:0]  preset_idx = {lvl_reg[`DFD_P_PMSB], lvl_reg[`DFD_P_PLSB]};
    wire [15:0] preset_ref = (preset_idx == 2'b00) ? PRESET_REF_1 :
                             (preset_idx == 2'b01) ? PRESET_REF_2 :
                             (preset_idx == 2'b10) ? PRESET_REF_3 : PRESET_REF_4; // [RULE9]
    wire        rst_start  = lvl_reg[`DFD_P_RSTART];
    wire        use_preset = (PRESET_FUNC & lvl_reg[`DFD_P_PON]) | rst_start; // [RULE10] [RULE16]
    wire [15:0] base_ref   = use_preset ? preset_ref : remote_sum;

    logic [15:0] held_ref_next, held_freq_next;
    logic        hold_ref_q_reg, hold_out_q_reg, rst_start_q_reg;
    always_comb begin
        held_ref_next  = HELD_REF;
        held_freq_next = HELD_FREQ;
        if (hold_ref && !hold_ref_q_reg) begin
            held_ref_next = base_ref; // capture on entry to hold
        end else if (hold_ref && step_dn && HELD_REF != 16'h0) begin
            held_ref_next = HELD_REF - `DFD_REF_STEP; // [RULE3] [RULE6]
        end else if (hold_ref && step_up && HELD_REF != 16'hffff) begin
            held_ref_next = HELD_REF + `DFD_REF_STEP;
        end
        if (hold_out && !hold_out_q_reg) begin
            held_freq_next = CURRENT_FREQ;
        end else if (hold_out && step_dn && HELD_FREQ != 16'h0) begin
            held_freq_next = HELD_FREQ - `DFD_FREQ_STEP; // [RULE3]
        end else if (hold_out && step_up && HELD_FREQ != 16'hffff) begin
            held_freq_next = HELD_FREQ + `DFD_FREQ_STEP;
        end
    end

    // catch-up / slow-down trims whatever reference is in force
    wire [15:0] pre_trim = hold_ref ? HELD_REF : base_ref;
    wire [31:0] trim     = (32'(pre_trim) * 32'(CATCH_PCT)) / 32'(`DFD_PCT_FULL);
    wire        slow     = lvl_reg[`DFD_P_SLOW];
    wire        catchup  = lvl_reg[`DFD_P_CATCH] & ~slow; // [RULE5]
    wire [31:0] raised   = 32'(pre_trim) + trim;
    wire [15:0] ref_next = slow    ? ((trim > 32'(pre_trim)) ? 16'h0 : 16'(32'(pre_trim) - trim)) :
                           catchup ? ((raised > 32'h0ffff) ? 16'hffff : raised[15:0]) :
                           pre_trim; // [RULE7]

    // in output hold the plain and accurate stops are ignored
    wire hard_stop = ~lvl_reg[`DFD_P_COAST_N] | ~lvl_reg[`DFD_P_QSTOP_N] |
                     ~lvl_reg[`DFD_P_DCBRK_N];
    wire halt_now  = ~lvl_reg[`DFD_P_HALT_N] | count_done_reg; // [RULE11] [RULE14]
    wire soft_stop = ~lvl_reg[`DFD_P_STOP_N] | halt_now;
    wire stop_next = hard_stop | (soft_stop & ~hold_out); // [RULE1]

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            HELD_REF        <= RETAINED_REF; // backup store reloads after supply loss [RULE6]
            HELD_FREQ       <= 16'h0;
            hold_ref_q_reg  <= 1'b0;
            hold_out_q_reg  <= 1'b0;
            rst_start_q_reg <= 1'b0;
            REF_OUT         <= 16'h0;
            FEEDBACK_OUT    <= 16'h0;
            SWEEP_FREQ      <= 16'h0;
            RAMP2_SEL       <= 1'b0;
            SETUP_SEL       <= 2'b00;
            STOP_REQ        <= 1'b0;
            HALT_REQ        <= 1'b0;
            RESET_PULSE     <= 1'b0;
            START_REQ       <= 1'b0;
            TIMEOUT_ARMED   <= 1'b0;
        end else begin
            HELD_REF        <= held_ref_next;
            HELD_FREQ       <= held_freq_next;
            hold_ref_q_reg  <= hold_ref;
            hold_out_q_reg  <= hold_out;
            rst_start_q_reg <= rst_start;
            REF_OUT         <= ref_next;
            FEEDBACK_OUT    <= is_pfb ? p_fb :
                               (VOLT_FUNC == dfd_pkg::DFD_AIN_FB) ? v_fb :
                               (CURR_FUNC == dfd_pkg::DFD_AIN_FB) ? i_fb : 16'h0; // [RULE13]
            SWEEP_FREQ      <= (VOLT_FUNC == dfd_pkg::DFD_AIN_SWEEP) ? v_sw :
                               (CURR_FUNC == dfd_pkg::DFD_AIN_SWEEP) ? i_sw : 16'h0; // [RULE20]
            RAMP2_SEL       <= lvl_reg[`DFD_P_RAMP] | hold_out; // [RULE8] [RULE3]
            if (MULTISETUP_EN) begin
                SETUP_SEL <= {lvl_reg[`DFD_P_SMSB], lvl_reg[`DFD_P_SLSB]}; // [RULE15]
            end
            STOP_REQ        <= stop_next;
            HALT_REQ        <= halt_now & ~hold_out;
            RESET_PULSE     <= rst_start & ~rst_start_q_reg; // [RULE16]
            START_REQ       <= rst_start;
            TIMEOUT_ARMED   <= (v_min > `DFD_TIMEOUT_MV); // [RULE22]
        end
    end

    chk_hold_only_steps: assert property (@(posedge CLOCK) disable iff (RST) // [RULE2]
        (!hold_ref && $past(!hold_ref)) |=> $stable(HELD_REF))
        else $error("held reference moved outside hold");
    chk_down_beats_up: assert property (@(posedge CLOCK) disable iff (RST) // [RULE5]
        (hold_ref && hold_ref_q_reg && step_hit[1] && HELD_REF != 16'h0)
        |=> HELD_REF == $past(HELD_REF) - 16'h1)
        else $error("decrease step did not win");
    chk_out_hold_stop: assert property (@(posedge CLOCK) disable iff (RST) // [RULE1]
        (hold_out && !hard_stop) |=> !STOP_REQ)
        else $error("soft stop honoured during output hold");
    chk_ramp_level: assert property (@(posedge CLOCK) disable iff (RST) // [RULE8]
        (!hold_out && lvl_reg[`DFD_P_RAMP]) ##1 1 |-> RAMP2_SEL)
        else $error("ramp two not selected");
    chk_preset_pick: assert property (@(posedge CLOCK) disable iff (RST) // [RULE9]
        (PRESET_FUNC && lvl_reg[`DFD_P_PON] && preset_idx == 2'b11 && !hold_ref
         && !slow && !lvl_reg[`DFD_P_CATCH]) |=> REF_OUT == $past(PRESET_REF_4))
        else $error("fourth preset not chosen");
    chk_setup_gate: assert property (@(posedge CLOCK) disable iff (RST) // [RULE15]
        !MULTISETUP_EN |=> $stable(SETUP_SEL))
        else $error("setup changed while switching disabled");
    chk_count_halt: assert property (@(posedge CLOCK) disable iff (RST) // [RULE14]
        (cnt_hit && !RESET_PULSE && !hold_out) |=> ##1 (HALT_REQ && STOP_REQ))
        else $error("counter target did not halt");
    chk_reset_start: assert property (@(posedge CLOCK) disable iff (RST) // [RULE16]
        $rose(rst_start) |=> (RESET_PULSE && START_REQ) ##1 !RESET_PULSE)
        else $error("reset-and-start pulse wrong");
    chk_halt_ramp: assert property (@(posedge CLOCK) disable iff (RST) // [RULE11]
        (!lvl_reg[`DFD_P_HALT_N] && !hold_out) |=> (HALT_REQ && STOP_REQ))
        else $error("accurate halt not requested");
    chk_pulse_zero: assert property (@(posedge CLOCK) disable iff (RST) // [RULE12]
        (PULSE_FREQ == 16'h0) |-> (p_ref == REF_MIN))
        else $error("zero pulse frequency not at minimum");

    cov_step_up:   cover property (@(posedge CLOCK) disable iff (RST) hold_ref && step_up);
    cov_count_hit: cover property (@(posedge CLOCK) disable iff (RST) cnt_hit);
    cov_reverse:   cover property (@(posedge CLOCK) disable iff (RST) $rose(ENC_REVERSE));
endmodule

// ==== sim/dfd_encoder_model.sv ====
// two-track encoder model that drives the a and b pins
`timescale 1ns/1ps
module dfd_encoder_model (
    input  wire logic CLOCK,
    input  wire logic run,
    input  wire logic reverse,
    output logic      TRACK_A,
    output logic      TRACK_B
);
    logic [3:0] phase_reg = 4'h0;
    // moves on the falling edge, like every other stimulus of the bench
    always_ff @(negedge CLOCK) begin
        if (run) begin
            phase_reg <= phase_reg + 4'h1;
        end
    end
    // b leads a when reversing, so b is high at each rise of a
    assign TRACK_A = phase_reg[3];
    assign TRACK_B = phase_reg[3] ^ phase_reg[2] ^ ~reverse;
endmodule

// ==== sim/drive_input_function_decoder_tb.sv ====
// testbench for the drive input function decoder
`timescale 1ns/1ps
module drive_input_function_decoder_tb;
    logic CLOCK, RST, SPEED_UP, SPEED_DOWN, CATCH_UP, SLOW_DOWN, RAMP_SELECT, PRESET_LSB;
    logic PRESET_MSB, PRESET_ENABLE, ACCURATE_HALT_INVERSE, SETUP_LSB, SETUP_MSB, TRACK_A;
    logic RESET_AND_START, TRACK_B, COAST_N, QUICK_STOP_N, DC_BRAKE_N, STOP_N, PRESET_FUNC;
    logic MULTISETUP_EN, SCALE_CUSTOM, run, rev, RAMP2_SEL, STOP_REQ, HALT_REQ, RESET_PULSE;
    logic START_REQ, ENC_REVERSE, TIMEOUT_ARMED;
    logic [1:0] SETUP_SEL;
    logic [7:0] CATCH_PCT;
    dfd_pkg::dfd_hold_t HOLD_MODE;
    dfd_pkg::dfd_pulse_t PULSE_MODE;
    dfd_pkg::dfd_ain_t VOLT_FUNC, CURR_FUNC;
    logic [15:0] RETAINED_REF, CURRENT_FREQ, REMOTE_REF, PRESET_REF_1, PRESET_REF_2, REF_MIN;
    logic [15:0] PRESET_REF_3, PRESET_REF_4, REF_MAX, FB_MIN, FB_MAX, PULSE_MAX_HZ, VOLT_IN;
    logic [15:0] COUNT_TARGET, SWEEP_DELTA, VOLT_MIN, VOLT_MAX, CURR_IN, CURR_MIN, CURR_MAX;
    logic [15:0] REF_OUT, HELD_REF, HELD_FREQ, FEEDBACK_OUT, SWEEP_FREQ, PULSE_FREQ, PULSE_COUNT;
    int bad_count = 0;
    int n_checks = 0;
    // short counts keep the step qualifier and the gate quick in simulation
    dfd_decoder #(.STEP_CYCLES(8), .GATE_CYCLES(64)) DUT (.*);
    dfd_encoder_model u_enc (.CLOCK(CLOCK), .run(run), .reverse(rev), .TRACK_A(TRACK_A),
                             .TRACK_B(TRACK_B));
    initial begin
        CLOCK = 1'b0;
        forever #4 CLOCK = ~CLOCK;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(negedge CLOCK);
    endtask
    // a pulse of 12 cycles high and 16 low qualifies against 8-cycle limits
    task automatic step(input logic up, input logic dn);
        {SPEED_UP, SPEED_DOWN} = {up, dn};
        settle(12);
        {SPEED_UP, SPEED_DOWN} = 2'b00;
        settle(16);
    endtask
    task automatic complete_run;
        if (bad_count == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        #20000;
        bad_count++;
        complete_run;
    end
    initial begin
        {RST, SPEED_UP, SPEED_DOWN, CATCH_UP, SLOW_DOWN, RAMP_SELECT, PRESET_LSB, PRESET_MSB,
         PRESET_ENABLE, SETUP_LSB, SETUP_MSB, RESET_AND_START, PRESET_FUNC, MULTISETUP_EN,
         SCALE_CUSTOM, run, rev, CATCH_PCT} = '0;
        {COAST_N, QUICK_STOP_N, DC_BRAKE_N, STOP_N, ACCURATE_HALT_INVERSE, RST} = '1;
        {CURRENT_FREQ, REF_MIN, FB_MIN, FB_MAX, PULSE_MAX_HZ, COUNT_TARGET, SWEEP_DELTA, VOLT_IN,
         VOLT_MIN, VOLT_MAX, CURR_IN, CURR_MIN, CURR_MAX} = '0;
        {PRESET_REF_1, PRESET_REF_2, PRESET_REF_3, PRESET_REF_4} = 64'h0100_0200_0300_0400;
        {RETAINED_REF, REMOTE_REF, REF_MAX} = 48'h0123_0050_ffff;
        HOLD_MODE = dfd_pkg::DFD_HOLD_NONE;
        PULSE_MODE = dfd_pkg::DFD_PM_NONE;
        VOLT_FUNC = dfd_pkg::DFD_AIN_NONE;
        CURR_FUNC = dfd_pkg::DFD_AIN_NONE;
        settle(20);
        RST = 1'b0;
        chk(HELD_REF, 16'h0123);
        {PRESET_FUNC, PRESET_ENABLE} = 2'b11;
        for (int i = 0; i < 4; i++) begin
            {PRESET_MSB, PRESET_LSB} = i[1:0];
            settle(8);
            chk(REF_OUT, {i[7:0] + 8'h01, 8'h00});
        end
        PRESET_ENABLE = 1'b0;
        RAMP_SELECT = 1'b1;
        settle(8);
        chk(REF_OUT, 16'h0050);
        chk({15'h0000, RAMP2_SEL}, 16'h0001);
        PRESET_ENABLE = 1'b1;
        step(1'b1, 1'b0);
        chk(HELD_REF, 16'h0123);
        HOLD_MODE = dfd_pkg::DFD_HOLD_REF;
        settle(8);
        step(1'b1, 1'b0);
        chk(HELD_REF, 16'h0401);
        step(1'b1, 1'b1);
        chk(HELD_REF, 16'h0400);
        HOLD_MODE = dfd_pkg::DFD_HOLD_NONE;
        PULSE_MODE = dfd_pkg::DFD_PM_ENC_REF;
        {run, rev} = 2'b11;
        settle(48);
        chk({15'h0000, ENC_REVERSE}, 16'h0001);
        rev = 1'b0;
        settle(48);
        chk({15'h0000, ENC_REVERSE}, 16'h0000);
        ACCURATE_HALT_INVERSE = 1'b0;
        settle(8);
        chk({15'h0000, HALT_REQ}, 16'h0001);
        {ACCURATE_HALT_INVERSE, COUNT_TARGET} = {1'b1, 16'h0003};
        PULSE_MODE = dfd_pkg::DFD_PM_ENC_CNT;
        settle(8);
        chk({15'h0000, HALT_REQ}, 16'h0000);
        settle(56);
        chk({15'h0000, HALT_REQ}, 16'h0001);
        {run, PRESET_ENABLE} = 2'b00;
        PULSE_MODE = dfd_pkg::DFD_PM_NONE;
        VOLT_FUNC = dfd_pkg::DFD_AIN_REF;
        CURR_FUNC = dfd_pkg::DFD_AIN_SWEEP;
        {VOLT_IN, CURR_IN, SWEEP_DELTA} = 48'h1388_2ee0_0032;
        settle(8);
        chk(REF_OUT, 16'h804f);
        chk(SWEEP_FREQ, 16'h0019);
        chk({15'h0000, TIMEOUT_ARMED}, 16'h0000);
        {SCALE_CUSTOM, VOLT_MIN, VOLT_MAX} = 33'h1_07d0_2710;
        settle(8);
        chk(REF_OUT, 16'h604f);
        chk({15'h0000, TIMEOUT_ARMED}, 16'h0001);
        complete_run;
    end
endmodule
